//--- logic/ais_defines.svh
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH
// ==========================================================
// Register offsets on the special function register port
`define AIS_OFF_BASE_LO 8'hd9
`define AIS_OFF_BASE_HI 8'hda
`define AIS_OFF_PTR_LO 8'hdb
`define AIS_OFF_PTR_HI 8'hdc
`define AIS_OFF_WIX 8'hdd
`define AIS_OFF_DATA 8'hde
`define AIS_OFF_LIM_LO 8'hf9
`define AIS_OFF_LIM_HI 8'hfa
`define AIS_OFF_CNT_LO 8'hfb
`define AIS_OFF_CNT_HI 8'hfc
`define AIS_OFF_START 8'hfd
`define AIS_OFF_CUR 8'hfe
// ==========================================================
// Instruction word fields
`define AIS_BIT_CONT 7
`define AIS_BIT_DIFF 6
`define AIS_BIT_CONV1 5
`define AIS_BIT_CONV0 4
// ==========================================================
// Reset values
`define AIS_RST_BYTE 8'h00
`define AIS_RST_IDX 6'h00
`define AIS_RST_WORD 16'h0000
`endif

//--- logic/ais_pkg.sv
// ==========================================================
// Types of the instruction sequencer
package ais_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		AIS_IDLE = 3'h0,
		AIS_FETCH = 3'h1,
		AIS_LOAD = 3'h2,
		AIS_WAIT = 3'h3,
		AIS_WRITE = 3'h4,
		AIS_STEP = 3'h5
	} ais_state_t;

	// Pending result sources: bit 2 differential, bit 1 conv1, bit 0 conv0
	typedef logic [2:0] ais_srcmask_t;
endpackage : ais_pkg

//--- logic/ais_imem.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Dual port instruction memory, registered read on both ports
module ais_imem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// Clock
	input wire logic clk_i,
	// Software port
	input wire logic a_we_i,
	input wire logic [AW-1:0] a_addr_i,
	input wire logic [WIDTH-1:0] a_wdata_i,
	output logic [WIDTH-1:0] a_rdata_o,
	// Sequencer fetch port
	input wire logic [AW-1:0] b_addr_i,
	output logic [WIDTH-1:0] b_rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Storage has no reset, its contents start undefined
	always_ff @(posedge clk_i) begin
		if (a_we_i) begin
			mem[a_addr_i] <= a_wdata_i;
		end
		a_rdata_o <= mem[a_addr_i];
		b_rdata_o <= mem[b_addr_i];
	end
endmodule : ais_imem
`default_nettype wire

//--- logic/ais_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ais_defines.svh"
module ais_sequencer #(
	parameter int IDX_W = 6,
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// Run control
	input wire logic run_start_i,
	input wire logic run_stop_i,
	output logic busy_o,
	// Converter results
	input wire logic conv0_valid_i,
	input wire logic [15:0] conv0_data_i,
	input wire logic conv1_valid_i,
	input wire logic [15:0] conv1_data_i,
	input wire logic diff_valid_i,
	input wire logic [15:0] diff_data_i,
	// External data memory write port
	output logic xram_we_o,
	output logic [15:0] xram_addr_o,
	output logic [7:0] xram_wdata_o,
	input wire logic xram_ready_i
);
	// ==========================================================
	// Declarations
	ais_pkg::ais_state_t state_q, state_d;
	ais_pkg::ais_srcmask_t pend_q, pend_d;
	logic [7:0] instr_q, instr_d;
	logic [15:0] base_q, ptr_q, lim_q, cnt_q;
	logic [15:0] ptr_d, cnt_d, ptr_hw, cnt_hw;
	logic [IDX_W-1:0] start_q, cur_q, wix_q, cur_d;
	logic [15:0] res_q;
	logic [7:0] rdata_d, wdata_q, imem_a_q, imem_b_q;
	logic we_q, hi_q, busy_q;
	logic go, to_start, cur_inc, cnt_dec, cnt_reload, latch;

	// Pick the next source to collect: differential or conv0 first, then conv1
	function automatic ais_pkg::ais_srcmask_t ais_pick(input ais_pkg::ais_srcmask_t p);
		if (p[2]) begin
			ais_pick = 3'h4;
		end else if (p[0]) begin
			ais_pick = 3'h1;
		end else begin
			ais_pick = {1'b0, p[1], 1'b0};
		end
	endfunction : ais_pick

	// Register hit decode
	function automatic logic ais_hit(input logic [7:0] a, input logic [7:0] off);
		ais_hit = (a == off);
	endfunction : ais_hit

	// ==========================================================
	// Register decode
	wire wr_base_lo = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_BASE_LO);
	wire wr_base_hi = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_BASE_HI);
	wire wr_ptr_lo = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_PTR_LO);
	wire wr_ptr_hi = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_PTR_HI);
	wire wr_wix = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_WIX);
	wire wr_data = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_DATA);
	wire rd_data = sfr_rd_i && ais_hit(sfr_addr_i, `AIS_OFF_DATA);
	wire wr_lim_lo = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_LIM_LO);
	wire wr_lim_hi = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_LIM_HI);
	wire wr_cnt_lo = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_CNT_LO);
	wire wr_cnt_hi = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_CNT_HI);
	wire wr_start = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_START);
	wire wr_cur = sfr_wr_i && ais_hit(sfr_addr_i, `AIS_OFF_CUR);
	wire data_acc = wr_data || rd_data;

	// Read selection, upper index bits read zero
	wire [7:0] idx_pad_start = {2'b00, start_q};
	wire [7:0] idx_pad_cur = {2'b00, cur_q};
	wire [7:0] idx_pad_wix = {2'b00, wix_q};
	always_comb begin
		unique case (sfr_addr_i)
			`AIS_OFF_BASE_LO: rdata_d = base_q[7:0];
			`AIS_OFF_BASE_HI: rdata_d = base_q[15:8];
			`AIS_OFF_PTR_LO: rdata_d = ptr_q[7:0];
			`AIS_OFF_PTR_HI: rdata_d = ptr_q[15:8];
			`AIS_OFF_WIX: rdata_d = idx_pad_wix;
			`AIS_OFF_DATA: rdata_d = imem_a_q;
			`AIS_OFF_LIM_LO: rdata_d = lim_q[7:0];
			`AIS_OFF_LIM_HI: rdata_d = lim_q[15:8];
			`AIS_OFF_CNT_LO: rdata_d = cnt_q[7:0];
			`AIS_OFF_CNT_HI: rdata_d = cnt_q[15:8];
			`AIS_OFF_START: rdata_d = idx_pad_start;
			`AIS_OFF_CUR: rdata_d = idx_pad_cur;
			default: rdata_d = `AIS_RST_BYTE;
		endcase
	end

	// ==========================================================
	// Instruction memory
	ais_imem #(
		.WIDTH(8),
		.DEPTH(DEPTH),
		.AW(IDX_W)
	) u_imem (
		.clk_i(clk_i),
		.a_we_i(wr_data),
		.a_addr_i(wix_q),
		.a_wdata_i(sfr_wdata_i),
		.a_rdata_o(imem_a_q),
		.b_addr_i(cur_q),
		.b_rdata_o(imem_b_q)
	);

	// ==========================================================
	// Result source selection
	wire [2:0] sel = ais_pick(pend_q);
	wire sel_valid = |(sel & {diff_valid_i, conv1_valid_i, conv0_valid_i});
	wire [15:0] sel_data = sel[2] ? diff_data_i : (sel[1] ? conv1_data_i : conv0_data_i);
	wire acc = we_q && xram_ready_i;
	wire fetched_eoo = (imem_b_q[`AIS_BIT_DIFF:`AIS_BIT_CONV0] == 3'h0);
	wire [2:0] pend_left = pend_q & ~sel;

	// Sequencer next state and strobes
	always_comb begin
		state_d = state_q;
		pend_d = pend_q;
		instr_d = instr_q;
		go = 1'b0;
		to_start = 1'b0;
		cur_inc = 1'b0;
		cnt_dec = 1'b0;
		cnt_reload = 1'b0;
		latch = 1'b0;
		unique case (state_q)
			ais_pkg::AIS_IDLE: begin
				if (run_start_i) begin
					go = 1'b1;
					state_d = ais_pkg::AIS_FETCH;
				end
			end
			ais_pkg::AIS_FETCH: begin
				state_d = ais_pkg::AIS_LOAD;
			end
			ais_pkg::AIS_LOAD: begin
				instr_d = imem_b_q;
				if (fetched_eoo) begin
					to_start = 1'b1;
					state_d = imem_b_q[`AIS_BIT_CONT] ? ais_pkg::AIS_FETCH : ais_pkg::AIS_IDLE;
				end else begin
					pend_d[2] = imem_b_q[`AIS_BIT_DIFF];
					pend_d[1] = imem_b_q[`AIS_BIT_CONV1];
					pend_d[0] = imem_b_q[`AIS_BIT_CONV0] && !imem_b_q[`AIS_BIT_DIFF];
					state_d = ais_pkg::AIS_WAIT;
				end
			end
			ais_pkg::AIS_WAIT: begin
				if (sel_valid) begin
					latch = 1'b1;
					state_d = ais_pkg::AIS_WRITE;
				end
			end
			ais_pkg::AIS_WRITE: begin
				if (acc && hi_q) begin
					pend_d = pend_left;
					state_d = (|pend_left) ? ais_pkg::AIS_WAIT : ais_pkg::AIS_STEP;
				end
			end
			ais_pkg::AIS_STEP: begin
				state_d = ais_pkg::AIS_FETCH;
				if (!instr_q[`AIS_BIT_CONT]) begin
					if (cnt_q <= 16'h0001) begin
						cnt_reload = 1'b1;
						cur_inc = 1'b1;
					end else begin
						cnt_dec = 1'b1;
					end
				end
			end
			default: state_d = ais_pkg::AIS_IDLE;
		endcase
		if (run_stop_i) begin
			state_d = ais_pkg::AIS_IDLE;
		end
	end

	// ==========================================================
	// Next values of pointer, counter and current index
	assign ptr_hw = go ? base_q : (acc ? 16'(ptr_q + 16'h0001) : ptr_q);
	assign ptr_d = {wr_ptr_hi ? sfr_wdata_i : ptr_hw[15:8], wr_ptr_lo ? sfr_wdata_i : ptr_hw[7:0]};
	assign cnt_hw = cnt_reload ? lim_q : (cnt_dec ? 16'(cnt_q - 16'h0001) : cnt_q);
	assign cnt_d = {wr_cnt_hi ? sfr_wdata_i : cnt_hw[15:8], wr_cnt_lo ? sfr_wdata_i : cnt_hw[7:0]};
	assign cur_d = wr_cur ? sfr_wdata_i[IDX_W-1:0] :
		((go || to_start) ? start_q :
		(cur_inc ? IDX_W'(cur_q + 1'b1) : cur_q));

	// Software registers and indices
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_q <= `AIS_RST_WORD;
			lim_q <= `AIS_RST_WORD;
			start_q <= `AIS_RST_IDX;
			wix_q <= `AIS_RST_IDX;
			sfr_rdata_o <= `AIS_RST_BYTE;
		end else begin
			base_q <= {wr_base_hi ? sfr_wdata_i : base_q[15:8], wr_base_lo ? sfr_wdata_i : base_q[7:0]};
			lim_q <= {wr_lim_hi ? sfr_wdata_i : lim_q[15:8], wr_lim_lo ? sfr_wdata_i : lim_q[7:0]};
			start_q <= wr_start ? sfr_wdata_i[IDX_W-1:0] : start_q;
			wix_q <= wr_wix ? sfr_wdata_i[IDX_W-1:0] : (data_acc ? IDX_W'(wix_q + 1'b1) : wix_q);
			sfr_rdata_o <= sfr_rd_i ? rdata_d : sfr_rdata_o;
		end
	end

	// Sequencer state and working registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ais_pkg::AIS_IDLE;
			pend_q <= 3'h0;
			instr_q <= `AIS_RST_BYTE;
			ptr_q <= `AIS_RST_WORD;
			cnt_q <= `AIS_RST_WORD;
			cur_q <= `AIS_RST_IDX;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pend_q <= pend_d;
			instr_q <= instr_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			cur_q <= cur_d;
			busy_q <= (state_d != ais_pkg::AIS_IDLE);
		end
	end

	// External memory write path, low byte then high byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			we_q <= 1'b0;
			hi_q <= 1'b0;
			res_q <= `AIS_RST_WORD;
			wdata_q <= `AIS_RST_BYTE;
		end else begin
			if (latch) begin
				res_q <= sel_data;
				wdata_q <= sel_data[7:0];
			end else if (acc && !hi_q) begin
				wdata_q <= res_q[15:8];
			end
			we_q <= run_stop_i ? 1'b0 : (latch ? 1'b1 : ((acc && hi_q) ? 1'b0 : we_q));
			hi_q <= (latch || run_stop_i) ? 1'b0 : (acc ? !hi_q : hi_q);
		end
	end

	// Outputs straight from flops
	assign busy_o = busy_q;
	assign xram_we_o = we_q;
	assign xram_addr_o = ptr_q;
	assign xram_wdata_o = wdata_q;

	// ==========================================================
	// Assertions
	default clocking ais_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	start_load_a: assert property (
		(state_q == ais_pkg::AIS_IDLE && run_start_i && !run_stop_i && !sfr_wr_i)
		|=> (cur_q == $past(start_q)) && (ptr_q == $past(base_q))
		##1 (state_q == ais_pkg::AIS_LOAD)
	) else $error("start did not load index and pointer");
	ptr_step_a: assert property (
		(acc && !sfr_wr_i && state_q != ais_pkg::AIS_IDLE)
		|=> ptr_q == 16'($past(ptr_q) + 16'h0001)
	) else $error("pointer did not advance after byte");
	wix_step_a: assert property (
		(data_acc && !wr_wix) |=> wix_q == IDX_W'($past(wix_q) + 1'b1)
	) else $error("write index did not advance");
	diff_only_a: assert property (
		(state_q == ais_pkg::AIS_LOAD && !fetched_eoo && imem_b_q[`AIS_BIT_DIFF] && !run_stop_i)
		|=> pend_q[2] && !pend_q[0]
	) else $error("conv0 collected beside differential");
	diff_take_a: assert property (
		(state_q == ais_pkg::AIS_WAIT && pend_q[2] && diff_valid_i && !run_stop_i)
		|=> we_q && (xram_wdata_o == $past(diff_data_i[7:0]))
	) else $error("differential result not stored");
	conv1_skip_a: assert property (
		(state_q == ais_pkg::AIS_LOAD && !fetched_eoo && !run_stop_i)
		|=> pend_q[1] == $past(imem_b_q[`AIS_BIT_CONV1])
	) else $error("conv1 selection wrong");
	cont_hold_a: assert property (
		(state_q == ais_pkg::AIS_STEP && instr_q[`AIS_BIT_CONT] && !sfr_wr_i)
		|=> $stable(cur_q) && $stable(cnt_q)
	) else $error("continuous run touched counter");
	cnt_step_a: assert property (
		(state_q == ais_pkg::AIS_STEP && !instr_q[`AIS_BIT_CONT] && !sfr_wr_i)
		|=> (($past(cnt_q) > 16'h0001) && cnt_q == 16'($past(cnt_q) - 16'h0001) && $stable(cur_q))
		|| (($past(cnt_q) <= 16'h0001) && cnt_q == $past(lim_q)
		&& cur_q == IDX_W'($past(cur_q) + 1'b1))
	) else $error("repeat counter step wrong");
	eoo_reload_a: assert property (
		(state_q == ais_pkg::AIS_LOAD && fetched_eoo && !sfr_wr_i && !run_stop_i)
		|=> (cur_q == $past(start_q))
		&& ((state_q == ais_pkg::AIS_FETCH) == $past(imem_b_q[`AIS_BIT_CONT]))
	) else $error("end of operation handling wrong");
	idx_upper_a: assert property (
		(sfr_rd_i && (ais_hit(sfr_addr_i, `AIS_OFF_START) || ais_hit(sfr_addr_i, `AIS_OFF_CUR)))
		|=> sfr_rdata_o[7:6] == 2'b00
	) else $error("index upper bits not zero");
	regs_reset_a: assert property (
		$past(rst_i) |-> base_q == 16'h0000 && ptr_q == 16'h0000
		&& lim_q == 16'h0000 && cnt_q == 16'h0000
	) else $error("registers not cleared by reset");
endmodule : ais_sequencer
`default_nettype wire

//--- verif/ais_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter results and external data memory facing the sequencer
module ais_far_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Result values chosen by the bench
	input wire logic [15:0] conv0_val_i,
	input wire logic [15:0] conv1_val_i,
	input wire logic [15:0] diff_val_i,
	// Converter results
	output logic conv0_valid_o,
	output logic [15:0] conv0_data_o,
	output logic conv1_valid_o,
	output logic [15:0] conv1_data_o,
	output logic diff_valid_o,
	output logic [15:0] diff_data_o,
	// External data memory
	input wire logic xram_we_i,
	input wire logic [15:0] xram_addr_i,
	input wire logic [7:0] xram_wdata_i,
	output logic xram_ready_o
);
	logic [7:0] mem [65536];
	logic [4:0] tick_q;
	// Free running tick paces results and memory stalls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_q <= 5'h00;
		end else begin
			tick_q <= tick_q + 5'h01;
		end
	end
	// Short result pulses at three rates, the differential one slowest
	assign conv0_valid_o = (tick_q[2:0] == 3'h3);
	assign conv1_valid_o = (tick_q[3:0] == 4'h9);
	assign diff_valid_o = (tick_q == 5'h11);
	// Outside a pulse the data lines show the inverse value
	assign conv0_data_o = conv0_valid_o ? conv0_val_i : ~conv0_val_i;
	assign conv1_data_o = conv1_valid_o ? conv1_val_i : ~conv1_val_i;
	assign diff_data_o = diff_valid_o ? diff_val_i : ~diff_val_i;
	// Memory stalls one cycle in four, and longer once a round
	assign xram_ready_o = (tick_q[1:0] != 2'h2) && (tick_q[4:2] != 3'h7);
	// Accepted bytes are stored
	always_ff @(posedge clk_i) begin
		if (xram_we_i && xram_ready_o) begin
			mem[xram_addr_i] <= xram_wdata_i;
		end
	end
endmodule : ais_far_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ais_defines.svh"
// ==========================================================
// Self-checking bench of the instruction sequencer
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic run_start = 1'b0;
	logic run_stop = 1'b0;
	logic [15:0] v0 = 16'h0000;
	logic [15:0] v1 = 16'h0000;
	logic [15:0] vd = 16'h0000;
	wire logic [7:0] sfr_rdata;
	wire logic busy, c0v, c1v, dv, we, rdy;
	wire logic [15:0] c0d, c1d, dd, waddr;
	wire logic [7:0] wdat;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'd82348;
	logic [7:0] exp_q [$];
	logic [7:0] offs [11] = '{`AIS_OFF_BASE_LO, `AIS_OFF_BASE_HI, `AIS_OFF_PTR_LO,
		`AIS_OFF_PTR_HI, `AIS_OFF_LIM_LO, `AIS_OFF_LIM_HI, `AIS_OFF_CNT_LO,
		`AIS_OFF_CNT_HI, `AIS_OFF_START, `AIS_OFF_CUR, `AIS_OFF_WIX};
	// Design and its far side
	ais_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr),
		.sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
		.run_start_i(run_start), .run_stop_i(run_stop), .busy_o(busy),
		.conv0_valid_i(c0v), .conv0_data_i(c0d), .conv1_valid_i(c1v), .conv1_data_i(c1d),
		.diff_valid_i(dv), .diff_data_i(dd), .xram_we_o(we), .xram_addr_o(waddr),
		.xram_wdata_o(wdat), .xram_ready_i(rdy));
	ais_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .conv0_val_i(v0), .conv1_val_i(v1),
		.diff_val_i(vd), .conv0_valid_o(c0v), .conv0_data_o(c0d), .conv1_valid_o(c1v),
		.conv1_data_o(c1d), .diff_valid_o(dv), .diff_data_o(dd), .xram_we_i(we),
		.xram_addr_i(waddr), .xram_wdata_i(wdat), .xram_ready_o(rdy));
	// Clock and hang guard
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	task automatic rnd(output logic [7:0] r);
		repeat (8) seed = lfsr_next(seed);
		r = seed[7:0];
	endtask : rnd
	// Bytes one instruction word leaves in memory, low byte first
	function automatic void push_word(input logic [7:0] w);
		if (w[`AIS_BIT_DIFF]) exp_q = {exp_q, vd[7:0], vd[15:8]};
		else if (w[`AIS_BIT_CONV0]) exp_q = {exp_q, v0[7:0], v0[15:8]};
		if (w[`AIS_BIT_CONV1]) exp_q = {exp_q, v1[7:0], v1[15:8]};
	endfunction : push_word
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_i);
		sfr_wr <= 1'b0;
	endtask : sfr_write
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_i);
		sfr_rd <= 1'b0;
		@(negedge clk_i);
		d = sfr_rdata;
	endtask : sfr_read
	// One-cycle start or stop request
	task automatic pulse(input logic stop);
		@(posedge clk_i);
		if (stop) begin
			run_stop <= 1'b1;
		end else begin
			run_start <= 1'b1;
		end
		@(posedge clk_i);
		run_stop <= 1'b0;
		run_start <= 1'b0;
		@(negedge clk_i);
	endtask : pulse
	task automatic wait_idle();
		for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(negedge clk_i);
		check("busy idle", busy, 1'b0);
	endtask : wait_idle
	task automatic print_verdict();
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		logic [7:0] r, s, t;
		logic [7:0] prog [4];
		logic [15:0] base;
		prog = '{8'h50, 8'h30, 8'h20, 8'h00};
		rnd(r); rnd(t); v0 = {r, t};
		rnd(r); rnd(t); v1 = {r, t};
		rnd(r); rnd(t); vd = {r, t};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped place
		foreach (offs[i]) begin
			sfr_read(offs[i], r);
			check("reset value", r, `AIS_RST_BYTE);
		end
		sfr_write(8'h80, 8'h5a);
		sfr_read(8'h80, r);
		check("unmapped", r, `AIS_RST_BYTE);
		// Byte registers keep any value
		for (int n = 0; n < 8; n++) begin
			rnd(r);
			sfr_write(offs[n], r);
			sfr_read(offs[n], t);
			check("byte register", t, r);
		end
		// Index registers keep six bits only
		rnd(r);
		sfr_write(`AIS_OFF_CUR, r | 8'hc0);
		sfr_read(`AIS_OFF_CUR, t);
		check("current index", t, {2'b00, r[5:0]});
		rnd(r);
		s = {2'b00, r[5:0]};
		sfr_write(`AIS_OFF_START, r | 8'hc0);
		sfr_read(`AIS_OFF_START, t);
		check("start index", t, s);
		// Program written and read back through the data port
		sfr_write(`AIS_OFF_WIX, s | 8'hc0);
		foreach (prog[n]) sfr_write(`AIS_OFF_DATA, prog[n]);
		sfr_read(`AIS_OFF_WIX, t);
		check("write index", t, (s + 8'h04) & 8'h3f);
		sfr_write(`AIS_OFF_WIX, s);
		foreach (prog[n]) begin
			sfr_read(`AIS_OFF_DATA, t);
			check("instruction", t, prog[n]);
		end
		sfr_read(`AIS_OFF_WIX, t);
		check("write index", t, (s + 8'h04) & 8'h3f);
		// Counted run: once, then twice per word up to end of operation
		rnd(r); rnd(t); base = {t, r};
		sfr_write(`AIS_OFF_BASE_LO, r);
		sfr_write(`AIS_OFF_BASE_HI, t);
		sfr_write(`AIS_OFF_LIM_LO, 8'h02);
		sfr_write(`AIS_OFF_LIM_HI, 8'h00);
		sfr_write(`AIS_OFF_CNT_LO, 8'h01);
		sfr_write(`AIS_OFF_CNT_HI, 8'h00);
		exp_q = {};
		push_word(prog[0]);
		repeat (2) push_word(prog[1]);
		repeat (2) push_word(prog[2]);
		pulse(1'b0);
		check("busy run", busy, 1'b1);
		wait_idle();
		foreach (exp_q[n]) check("xram byte", i_far.mem[base + n[15:0]], exp_q[n]);
		sfr_read(`AIS_OFF_PTR_LO, r);
		sfr_read(`AIS_OFF_PTR_HI, t);
		check("pointer", {t, r}, base + 16'h000e);
		sfr_read(`AIS_OFF_CUR, t);
		check("current reload", t, s);
		sfr_read(`AIS_OFF_CNT_LO, t);
		check("count reload", t, 8'h02);
		// End of operation with continuous bit loops back to the start word
		sfr_write(`AIS_OFF_WIX, s);
		sfr_write(`AIS_OFF_DATA, 8'h10);
		sfr_write(`AIS_OFF_DATA, 8'h80);
		sfr_write(`AIS_OFF_LIM_LO, 8'h01);
		sfr_write(`AIS_OFF_CNT_LO, 8'h01);
		pulse(1'b0);
		repeat (300) @(negedge clk_i);
		check("busy loop", busy, 1'b1);
		pulse(1'b1);
		wait_idle();
		check("xram loop", i_far.mem[base + 16'h0004], v0[7:0]);
		// Continuous word repeats without touching counter or index
		sfr_write(`AIS_OFF_WIX, s);
		sfr_write(`AIS_OFF_DATA, 8'h90);
		sfr_write(`AIS_OFF_CNT_LO, 8'h05);
		pulse(1'b0);
		repeat (200) @(posedge clk_i);
		sfr_read(`AIS_OFF_CUR, t);
		check("current hold", t, s);
		sfr_read(`AIS_OFF_CNT_LO, t);
		check("count hold", t, 8'h05);
		pulse(1'b1);
		wait_idle();
		check("xram low", i_far.mem[base], v0[7:0]);
		check("xram high", i_far.mem[base + 16'h0001], v0[15:8]);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
